// ==== verif/ppcd_host.sv ====
// ppcd_host: host processor model on the muxed utility bus
// assumes the device syncs the strobes to i_clk; all bus moves follow a rising edge
`timescale 1ns/100ps
module ppcd_host (
  // clock
  input  wire logic       i_clk,
  // device answer
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_oe_n,
  // bus pins
  output logic      [7:0] o_ad,
  output logic            o_ale,
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n
);
  // idle bus: strobes inactive, latch strobe low
  initial
  begin
    o_ad   = 8'hA5;
    o_ale  = 1'b0;
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
  endtask : step

  // address taken by the device on the falling latch strobe
  task automatic addr(input logic [3:0] a);
    o_ad  <= {4'h0, a};
    o_ale <= 1'b1;
    step(5);
    o_ale <= 1'b0;
    step(5);
  endtask : addr

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr(a);
    o_ad   <= d;
    o_cs_n <= 1'b0;
    step(1);
    o_wr_n <= 1'b0;
    step(5);
    o_wr_n <= 1'b1;
    step(5);
    o_cs_n <= 1'b1;
    // released lines show the inverse, not the stale value
    o_ad   <= ~d;
    step(5);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr(a);
    o_ad   <= ~{4'h0, a};
    o_cs_n <= 1'b0;
    o_rd_n <= 1'b0;
    for (int k = 0; k < 20 && i_oe_n !== 1'b0; k++) step(1);
    step(1);
    d = i_rdata;
    o_rd_n <= 1'b1;
    // select stays low past the strobe so the device sees the read end
    step(5);
    o_cs_n <= 1'b1;
    step(5);
  endtask : rd
endmodule : ppcd_host

// ==== verif/testbench.sv ====
// testbench: self-checking bench for ppcd_port
// assumes ppcd_host speaks the utility bus; line events are pulsed here
`timescale 1ns/100ps
module testbench;
  localparam int HOLD = 4;
  logic                 clk;
  logic                 srst;
  ppcd_pkg::ppcd_evt_s  evt;
  logic                 mode;
  logic [7:0]           ad;
  logic [7:0]           rdata;
  logic                 ale;
  logic                 cs_n;
  logic                 rd_n;
  logic                 wr_n;
  logic                 oe_n;
  logic                 int_n;
  logic                 rx_led;
  logic                 tx_led;
  ppcd_pkg::ppcd_path_s path;
  int                   n_errors;
  int                   check_count;
  logic [7:0]           st;

  ppcd_host host (.i_clk(clk), .i_rdata(rdata), .i_oe_n(oe_n), .o_ad(ad), .o_ale(ale), .o_cs_n(cs_n),
                  .o_rd_n(rd_n), .o_wr_n(wr_n));
  ppcd_port #(.ACT_HOLD(HOLD)) dut (.i_clk(clk), .i_srst(srst), .i_ad(ad), .i_ale(ale), .i_cs_n(cs_n),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .o_ad(rdata), .o_ad_oe_n(oe_n), .i_evt(evt), .i_nibble_cell_port_mode(mode),
    .o_int_n(int_n), .o_rx_activity_led(rx_led), .o_tx_activity_led(tx_led), .o_path(path));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // evt bits: rx_cell 40, rx_idle 20, tx_cell 10, hec 08, short 04, sym 02, other 01
  task automatic pulse(input logic [6:0] e, input int n);
    repeat (n)
    begin
      evt <= ppcd_pkg::ppcd_evt_s'(e);
      @(posedge clk);
      evt <= '0;
      @(posedge clk);
    end
  endtask : pulse

  // snapshot one counter; the select write also zeroes it
  task automatic cnt(input logic [7:0] sel, input logic [15:0] exp);
    logic [7:0] lo;
    logic [7:0] hi;
    host.wr(ppcd_pkg::OFF_CNT_SEL, sel);
    host.step(50);
    host.rd(ppcd_pkg::OFF_CNT_LO, lo);
    host.rd(ppcd_pkg::OFF_CNT_HI, hi);
    chk({hi, lo}, exp);
  endtask : cnt

  // exp_st of FF skips the status value where masking leaves it open
  task automatic irq(input logic [7:0] m, input logic [7:0] k, input logic [6:0] e, input logic ei,
                     input logic [7:0] es);
    host.wr(ppcd_pkg::OFF_MASTER, m);
    host.wr(ppcd_pkg::OFF_IMASK, k);
    // earlier scenarios leave sticky bits behind
    host.rd(ppcd_pkg::OFF_ISTAT, st);
    pulse(e, 1);
    host.step(4);
    chk(int_n, ei);
    host.rd(ppcd_pkg::OFF_ISTAT, st);
    if (es !== 8'hFF) chk(st, es);
    chk(int_n, 1'b1);
    host.rd(ppcd_pkg::OFF_ISTAT, st);
    chk(st, 8'h00);
  endtask : irq

  task automatic paths();
    logic [1:0] lb [3];
    lb = '{ppcd_pkg::LB_PHY, ppcd_pkg::LB_LINE, ppcd_pkg::LB_NORMAL};
    foreach (lb[i])
    begin
      host.wr(ppcd_pkg::OFF_DIAG, {6'h00, lb[i]});
      chk({path.phy_loop, path.line_loop}, {lb[i] == ppcd_pkg::LB_PHY, lb[i] == ppcd_pkg::LB_LINE});
    end
    mode <= 1'b1;
    host.wr(ppcd_pkg::OFF_ENH, 8'h60);
    chk(path.loop_timing, 1'b1);
    chk(path.hdr_swap, 1'b1);
    mode <= 1'b0;
    host.step(3);
    chk(path.hdr_swap, 1'b0);
  endtask : paths

  task automatic leds();
    pulse(7'h50, 1);
    chk({rx_led, tx_led}, 2'b00);
    host.step(HOLD + 6);
    chk({rx_led, tx_led}, 2'b11);
  endtask : leds

  initial
  begin
    srst = 1'b1;
    evt = '0;
    mode = 1'b0;
    n_errors = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({int_n, rx_led, tx_led, oe_n, path}, 8'hF0);
    host.rd(ppcd_pkg::OFF_MASTER, st);
    chk(st, ppcd_pkg::RST_MASTER);
    host.rd(4'hF, st);
    chk(st, 8'h00);
    pulse(7'h10, 3);
    cnt(8'h02, 16'h0003);
    cnt(8'h02, 16'h0000);
    pulse(7'h40, 4);
    pulse(7'h60, 1);
    pulse(7'h48, 1);
    cnt(8'h04, 16'h0004);
    cnt(8'h08, 16'h0001);
    pulse(7'h02, 300);
    cnt(8'h01, 16'h002C);
    irq(8'h49, 8'h00, 7'h01, 1'b0, 8'h08);
    irq(8'h49, 8'h08, 7'h01, 1'b1, 8'hFF);
    irq(8'h69, 8'h00, 7'h01, 1'b1, 8'hFF);
    irq(8'h69, 8'h00, 7'h04, 1'b0, 8'h02);
    irq(8'h69, 8'h00, 7'h02, 1'b0, 8'h04);
    irq(8'h48, 8'h00, 7'h08, 1'b1, 8'h01);
    leds();
    paths();
    print_verdict();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule : testbench

// ==== verilog/ppcd_pkg.sv ====
// ppcd_pkg: constants and carrier types for the port control and diagnostics block
// assumes one port's register slice at the low nibble of the utility bus address
package ppcd_pkg;
  // register offsets within a port
  localparam logic [3:0] OFF_MASTER   = 4'h0;
  localparam logic [3:0] OFF_ISTAT    = 4'h1;
  localparam logic [3:0] OFF_DIAG     = 4'h2;
  localparam logic [3:0] OFF_CNT_LO   = 4'h4;
  localparam logic [3:0] OFF_CNT_HI   = 4'h5;
  localparam logic [3:0] OFF_CNT_SEL  = 4'h6;
  localparam logic [3:0] OFF_IMASK    = 4'h7;
  localparam logic [3:0] OFF_ENH      = 4'h8;
  // field positions
  localparam int BIT_INT_EN     = 0;
  localparam int BIT_CELL_ONLY  = 5;
  localparam int BIT_LOOP_TIME  = 6;
  localparam int BIT_SWAP       = 5;
  localparam int BIT_SEL_SYM    = 0;
  localparam int BIT_SEL_TX     = 1;
  localparam int BIT_SEL_RX     = 2;
  localparam int BIT_SEL_HEC    = 3;
  // interrupt status bits
  localparam int ST_HEC   = 0;
  localparam int ST_SHORT = 1;
  localparam int ST_SYM   = 2;
  localparam int ST_OTHER = 3;
  localparam logic [7:0] CELL_ERR_MASK = 8'h07;
  // reset values
  localparam logic [7:0] RST_MASTER = 8'h49;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  // loopback encodings
  localparam logic [1:0] LB_NORMAL = 2'h0;
  localparam logic [1:0] LB_PHY    = 2'h2;
  localparam logic [1:0] LB_LINE   = 2'h3;
  // counter widths
  localparam int SYM_W = 8;
  localparam int CEL_W = 16;
  localparam int HEC_W = 5;

  typedef enum logic [2:0] {
    PPCD_IDLE = 3'b001,
    PPCD_ADDR = 3'b010,
    PPCD_DATA = 3'b100
  } ppcd_bus_e;

  // line-side events of one clock
  typedef struct packed {
    logic rx_cell;
    logic rx_idle;
    logic tx_cell;
    logic hec_err;
    logic short_cell;
    logic sym_err;
    logic other_evt;
  } ppcd_evt_s;

  typedef struct packed {
    logic       phy_loop;
    logic       line_loop;
    logic       loop_timing;
    logic       hdr_swap;
  } ppcd_path_s;
endpackage : ppcd_pkg

// ==== verilog/ppcd_port.sv ====
// ppcd_port: register slice, interrupt, LED, loopback and counters of one line port
// assumes utility bus pins are raw async pins; events come from logic on i_clk
//
// Contract
// (R1) host idles read, write, select high and latch strobe low before writing
// (R2) address taken from shared lines on falling edge of latch strobe
// (R3) write data stored when write strobe returns high with select low
// (R4) cleared overall enable blocks all interrupt signalling of the port
// (R5) each interrupt source maskable through the interrupt mask register
// (R6) cell-error-only bit lets only HEC, short cell, symbol errors interrupt
// (R7) enabled, unmasked condition drives active-low interrupt output low
// (R8) reading interrupt status clears sticky bits and releases interrupt
// (R9) receive LED low while cells received, high otherwise
// (R10) transmit LED low while cells transmitted, high otherwise
// (R11) diagnostic bits 00 normal, 10 PHY loopback, 11 line loopback
// (R12) PHY loopback returns transmit cells internally, line is cut off
// (R13) line loopback retransmits line data and still delivers it upstream
// (R14) 8-bit symbol error counter counts invalid line symbols
// (R15) 16-bit transmit cell counter counts transmitted cells
// (R16) 16-bit receive cell counter skips idle and HEC errored cells
// (R17) 5-bit HEC error counter counts HEC errors
// (R18) select write snapshots counter into byte registers, then zeroes it
// (R19) host sets only one counter select bit at a time
// (R20) host waits 12.5 over line rate microseconds before reading bytes
// (R21) loop timing bit picks recovered receive clock for transmitter
// (R22) swap bit in nibble cell port mode exchanges two header bytes
// (R23) with enable clear interrupt stays high, status still updates
// (R24) swapped header byte positions come from a separately confirmed mapping
`timescale 1ns/100ps
module ppcd_port #(
  parameter int ACT_HOLD = 1000
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  // utility bus pins
  input  wire logic [7:0]           i_ad,
  input  wire logic                 i_ale,
  input  wire logic                 i_cs_n,
  input  wire logic                 i_rd_n,
  input  wire logic                 i_wr_n,
  output logic      [7:0]           o_ad,
  output logic                      o_ad_oe_n,
  // line-side events
  input  wire ppcd_pkg::ppcd_evt_s  i_evt,
  input  wire logic                 i_nibble_cell_port_mode,
  // outputs
  output logic                      o_int_n,
  output logic                      o_rx_activity_led,
  output logic                      o_tx_activity_led,
  output ppcd_pkg::ppcd_path_s      o_path
);
  typedef struct packed {
    logic [2:0]            ad_s1, ale_s1, cs_s1;
    logic [7:0]            ad0, ad1, ad2;
    logic [2:0]            ale_p, cs_p, rd_p, wr_p;
    ppcd_pkg::ppcd_bus_e   bus;
    logic [3:0]            addr;
    logic [7:0]            master, diag, imask, enh, csel, istat;
    logic [7:0]            snap_lo, snap_hi;
    logic [ppcd_pkg::SYM_W-1:0] sym_cnt;
    logic [ppcd_pkg::CEL_W-1:0] tx_cnt, rx_cnt;
    logic [ppcd_pkg::HEC_W-1:0] hec_cnt;
    logic [9:0]            rx_hold, tx_hold;
    logic [7:0]            rd_data;
    logic                  rd_oe_n, int_n, rx_led, tx_led;
    ppcd_pkg::ppcd_path_s  path;
  } ppcd_state_s;

  ppcd_state_s st_ff;
  ppcd_state_s nxt_st;

  localparam logic [9:0] HOLD = 10'(ACT_HOLD);

  logic ale_fall, wr_rise, rd_fall, rd_rise, cs_low, rd_stat;
  logic [7:0] pend;

  // three-stage pin sync; a change counts once stages two and three agree
  assign ale_fall = (st_ff.ale_p[1] == st_ff.ale_p[2]) && !st_ff.ale_p[1] && st_ff.ale_s1[0];
  assign wr_rise  = st_ff.wr_p[1] && st_ff.wr_p[2] && st_ff.ale_s1[1];
  assign rd_fall  = !st_ff.rd_p[1] && !st_ff.rd_p[2] && st_ff.ale_s1[2];
  assign rd_rise  = st_ff.rd_p[1] && st_ff.rd_p[2] && !st_ff.cs_s1[0];
  assign cs_low   = !st_ff.cs_p[1] && !st_ff.cs_p[2];
  assign rd_stat  = rd_rise && cs_low && st_ff.addr == ppcd_pkg::OFF_ISTAT;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.ad0   = i_ad;
    nxt_st.ad1   = st_ff.ad0;
    nxt_st.ad2   = st_ff.ad1;
    nxt_st.ale_p = {st_ff.ale_p[1:0], i_ale};
    nxt_st.cs_p  = {st_ff.cs_p[1:0], i_cs_n};
    nxt_st.rd_p  = {st_ff.rd_p[1:0], i_rd_n};
    nxt_st.wr_p  = {st_ff.wr_p[1:0], i_wr_n};
    // edge history: previous agreed level of latch and read strobes, inverted level of write strobe
    if (st_ff.ale_p[1] == st_ff.ale_p[2]) nxt_st.ale_s1[0] = st_ff.ale_p[2];
    if (st_ff.wr_p[1] == st_ff.wr_p[2])   nxt_st.ale_s1[1] = !st_ff.wr_p[2];
    if (st_ff.rd_p[1] == st_ff.rd_p[2])   nxt_st.ale_s1[2] = st_ff.rd_p[2];
    if (st_ff.rd_p[1] == st_ff.rd_p[2])   nxt_st.cs_s1[0]  = st_ff.rd_p[2];
    nxt_st.cs_s1[2:1] = 2'b00;
    nxt_st.ad_s1 = 3'b000;

    case (st_ff.bus)
      ppcd_pkg::PPCD_IDLE: if (st_ff.ale_p[2]) nxt_st.bus = ppcd_pkg::PPCD_ADDR;
      ppcd_pkg::PPCD_ADDR:
        if (ale_fall)
        begin
          nxt_st.addr = st_ff.ad2[3:0];     // [R2]
          nxt_st.bus  = ppcd_pkg::PPCD_DATA;
        end
      ppcd_pkg::PPCD_DATA: if (st_ff.ale_p[2]) nxt_st.bus = ppcd_pkg::PPCD_ADDR;
      default: nxt_st.bus = ppcd_pkg::PPCD_IDLE;
    endcase

    // counters [R14] [R15] [R16] [R17]
    if (i_evt.sym_err) nxt_st.sym_cnt = st_ff.sym_cnt + 1'b1;
    if (i_evt.tx_cell) nxt_st.tx_cnt  = st_ff.tx_cnt + 1'b1;
    if (i_evt.rx_cell && !i_evt.rx_idle && !i_evt.hec_err) nxt_st.rx_cnt = st_ff.rx_cnt + 1'b1;
    if (i_evt.hec_err) nxt_st.hec_cnt = st_ff.hec_cnt + 1'b1;

    // sticky status keeps updating whatever the enable [R23]
    pend = '0;
    pend[ppcd_pkg::ST_HEC]   = i_evt.hec_err;
    pend[ppcd_pkg::ST_SHORT] = i_evt.short_cell;
    pend[ppcd_pkg::ST_SYM]   = i_evt.sym_err;
    pend[ppcd_pkg::ST_OTHER] = i_evt.other_evt;
    // set wins over the clear of a status read [R8]
    nxt_st.istat = (rd_stat ? 8'h00 : st_ff.istat) | pend;

    if (wr_rise && cs_low && st_ff.bus == ppcd_pkg::PPCD_DATA)   // [R3]
    begin
      case (st_ff.addr)
        ppcd_pkg::OFF_MASTER: nxt_st.master = st_ff.ad2;
        ppcd_pkg::OFF_DIAG:   nxt_st.diag   = st_ff.ad2;
        ppcd_pkg::OFF_IMASK:  nxt_st.imask  = st_ff.ad2;
        ppcd_pkg::OFF_ENH:    nxt_st.enh    = st_ff.ad2;
        ppcd_pkg::OFF_CNT_SEL:
        begin
          nxt_st.csel = st_ff.ad2;
          // one bit assumed set; lowest wins otherwise [R19] [R18]
          if (st_ff.ad2[ppcd_pkg::BIT_SEL_SYM])
          begin
            nxt_st.snap_lo = st_ff.sym_cnt;
            nxt_st.snap_hi = 8'h00;
            nxt_st.sym_cnt = '0;
          end
          else if (st_ff.ad2[ppcd_pkg::BIT_SEL_TX])
          begin
            {nxt_st.snap_hi, nxt_st.snap_lo} = st_ff.tx_cnt;
            nxt_st.tx_cnt = '0;
          end
          else if (st_ff.ad2[ppcd_pkg::BIT_SEL_RX])
          begin
            {nxt_st.snap_hi, nxt_st.snap_lo} = st_ff.rx_cnt;
            nxt_st.rx_cnt = '0;
          end
          else if (st_ff.ad2[ppcd_pkg::BIT_SEL_HEC])
          begin
            nxt_st.snap_lo = {3'h0, st_ff.hec_cnt};
            nxt_st.snap_hi = 8'h00;
            nxt_st.hec_cnt = '0;
          end
        end
        default: ;
      endcase
    end

    // read data; status is presented before its clear
    if (rd_fall && cs_low)
    begin
      nxt_st.rd_oe_n = 1'b0;
      case (st_ff.addr)
        ppcd_pkg::OFF_MASTER:  nxt_st.rd_data = st_ff.master;
        ppcd_pkg::OFF_ISTAT:   nxt_st.rd_data = st_ff.istat;
        ppcd_pkg::OFF_DIAG:    nxt_st.rd_data = st_ff.diag;
        ppcd_pkg::OFF_CNT_LO:  nxt_st.rd_data = st_ff.snap_lo;
        ppcd_pkg::OFF_CNT_HI:  nxt_st.rd_data = st_ff.snap_hi;
        ppcd_pkg::OFF_CNT_SEL: nxt_st.rd_data = st_ff.csel;
        ppcd_pkg::OFF_IMASK:   nxt_st.rd_data = st_ff.imask;
        ppcd_pkg::OFF_ENH:     nxt_st.rd_data = st_ff.enh;
        default:               nxt_st.rd_data = 8'h00;
      endcase
    end
    else if (st_ff.rd_p[1] && st_ff.rd_p[2])
      nxt_st.rd_oe_n = 1'b1;

    // interrupt gating [R4] [R5] [R6] [R7]
    nxt_st.int_n = !(st_ff.master[ppcd_pkg::BIT_INT_EN] &&
                     |(nxt_st.istat & ~st_ff.imask &
                       (st_ff.master[ppcd_pkg::BIT_CELL_ONLY] ? ppcd_pkg::CELL_ERR_MASK : 8'hFF)));

    // activity stretched so the LED is visible between cells [R9] [R10]
    nxt_st.rx_hold = i_evt.rx_cell ? HOLD : (st_ff.rx_hold != 10'h000 ? st_ff.rx_hold - 10'h001 : 10'h000);
    nxt_st.tx_hold = i_evt.tx_cell ? HOLD : (st_ff.tx_hold != 10'h000 ? st_ff.tx_hold - 10'h001 : 10'h000);
    nxt_st.rx_led  = !(i_evt.rx_cell || st_ff.rx_hold != 10'h000);
    nxt_st.tx_led  = !(i_evt.tx_cell || st_ff.tx_hold != 10'h000);

    // datapath steering [R11] [R12] [R13] [R21] [R22] [R24]
    nxt_st.path.phy_loop    = st_ff.diag[1:0] == ppcd_pkg::LB_PHY;
    nxt_st.path.line_loop   = st_ff.diag[1:0] == ppcd_pkg::LB_LINE;
    nxt_st.path.loop_timing = st_ff.enh[ppcd_pkg::BIT_LOOP_TIME];
    nxt_st.path.hdr_swap    = st_ff.enh[ppcd_pkg::BIT_SWAP] && i_nibble_cell_port_mode;

    if (i_srst)
    begin
      nxt_st         = '0;
      nxt_st.bus     = ppcd_pkg::PPCD_IDLE;
      nxt_st.master  = ppcd_pkg::RST_MASTER;
      nxt_st.ale_p   = 3'b000;
      nxt_st.cs_p    = 3'b111;
      nxt_st.rd_p    = 3'b111;
      nxt_st.wr_p    = 3'b111;
      // idle history: latch strobe low, write high, read high, so no false edge
      nxt_st.ale_s1  = 3'b100;
      nxt_st.cs_s1   = 3'b001;
      nxt_st.rd_oe_n = 1'b1;
      nxt_st.int_n   = 1'b1;
      nxt_st.rx_led  = 1'b1;
      nxt_st.tx_led  = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    st_ff <= nxt_st;
  end

  assign o_ad              = st_ff.rd_data;
  assign o_ad_oe_n         = st_ff.rd_oe_n;
  assign o_int_n           = st_ff.int_n;
  assign o_rx_activity_led = st_ff.rx_led;
  assign o_tx_activity_led = st_ff.tx_led;
  assign o_path            = st_ff.path;

  property p_int_off;
    @(posedge i_clk) disable iff (i_srst)
      !st_ff.master[ppcd_pkg::BIT_INT_EN] |=> o_int_n;
  endproperty
  a_int_off: assert property (p_int_off) else $error("interrupt asserted while disabled"); // [R4]

  property p_cell_only;
    @(posedge i_clk) disable iff (i_srst)
      st_ff.master[ppcd_pkg::BIT_CELL_ONLY] && (nxt_st.istat & ppcd_pkg::CELL_ERR_MASK) == 8'h00 |=> o_int_n;
  endproperty
  a_cell_only: assert property (p_cell_only) else $error("non cell error raised interrupt"); // [R6]

  property p_int_on;
    @(posedge i_clk) disable iff (i_srst)
      st_ff.master[ppcd_pkg::BIT_INT_EN] && !st_ff.master[ppcd_pkg::BIT_CELL_ONLY]
      && |(nxt_st.istat & ~st_ff.imask) |=> !o_int_n;
  endproperty
  a_int_on: assert property (p_int_on) else $error("unmasked event did not interrupt"); // [R7] [R5]

  property p_stat_clr;
    @(posedge i_clk) disable iff (i_srst)
      rd_stat && pend == 8'h00 |=> st_ff.istat == 8'h00;
  endproperty
  a_stat_clr: assert property (p_stat_clr) else $error("status not cleared by read"); // [R8]

  property p_rx_led;
    @(posedge i_clk) disable iff (i_srst)
      i_evt.rx_cell |=> !o_rx_activity_led [*2];
  endproperty
  a_rx_led: assert property (p_rx_led) else $error("receive led not lit"); // [R9]

  property p_tx_led;
    @(posedge i_clk) disable iff (i_srst)
      i_evt.tx_cell |=> !o_tx_activity_led;
  endproperty
  a_tx_led: assert property (p_tx_led) else $error("transmit led not lit"); // [R10]

  property p_loop;
    @(posedge i_clk) disable iff (i_srst)
      st_ff.diag[1:0] == ppcd_pkg::LB_NORMAL |=> !o_path.phy_loop && !o_path.line_loop;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback active in normal mode"); // [R11]

  property p_tx_cnt;
    @(posedge i_clk) disable iff (i_srst)
      i_evt.tx_cell && !(wr_rise && cs_low) |=> st_ff.tx_cnt == $past(st_ff.tx_cnt) + 16'h0001;
  endproperty
  a_tx_cnt: assert property (p_tx_cnt) else $error("transmit cell count missed"); // [R15]

  // a write strobe counts only in the data phase with select held low
  sequence s_diag_write;
    wr_rise && cs_low && st_ff.bus == ppcd_pkg::PPCD_DATA && st_ff.addr == ppcd_pkg::OFF_DIAG;
  endsequence

  property p_diag_wr;
    @(posedge i_clk) disable iff (i_srst)
      s_diag_write |=> st_ff.diag == $past(st_ff.ad2);
  endproperty
  a_diag_wr: assert property (p_diag_wr) else $error("diagnostic write lost"); // [R3]

  sequence s_tx_select;
    wr_rise && cs_low && st_ff.bus == ppcd_pkg::PPCD_DATA && st_ff.addr == ppcd_pkg::OFF_CNT_SEL
      && st_ff.ad2 == 8'h02;
  endsequence

  property p_snap_tx;
    @(posedge i_clk) disable iff (i_srst)
      s_tx_select |=> {st_ff.snap_hi, st_ff.snap_lo} == $past(st_ff.tx_cnt) && st_ff.tx_cnt == 16'h0000;
  endproperty
  a_snap_tx: assert property (p_snap_tx) else $error("transmit count not snapshotted"); // [R18]
endmodule : ppcd_port
